// file: led_model.sv
// bi-color lamp: two independent elements, code 0 dark 1 green 2 yellow
module led_model (
    // element drive
    input wire logic green_i,
    input wire logic yellow_i,
    // colour seen on the panel, 3 if both lit
    output logic [1:0] color_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // both elements lit would read amber, so it gets its own code
    assign color_o = {yellow_i, green_i};
endmodule // led_model

// file: led_seq.sv
`include "led_seq_cfg.svh"
// Notes on behaviour
// - separate green and yellow drive outputs
// - all channels up: steady green
// - all channels disabled: steady yellow
// - mixed: channel lit 0.22 s, green if up
// - mixed: faulty or disabled channel lit yellow
// - dark 0.22 s after each lit slot
// - slots advance from channel zero upward
// - after last channel dark 1.76 s, restart
module led_seq
    import led_seq_pkg::*;
#(
    parameter cnt_t SLOT_CYC = cnt_t'(`LED_SLOT_CYC),
    parameter cnt_t PAUSE_CYC = cnt_t'(`LED_PAUSE_CYC)
)
(
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    // per-channel status from channel logic
    input wire logic [`LED_NUM_CH-1:0] CH_UP_I,
    input wire logic [`LED_NUM_CH-1:0] CH_OFF_I,
    // led drive
    output logic LED_GREEN_O,
    output logic LED_YELLOW_O
);
    seq_state_e state_q;
    seq_state_e state_d;
    ch_idx_t ch_q;
    ch_idx_t ch_d;
    led_drive_s led_q;
    led_drive_s led_d;
    logic t_done;
    logic t_load;
    cnt_t t_len;
    logic all_up;
    logic all_off;
    logic last_ch;
    logic solid;
    ch_idx_t next_ch;
    logic first_ok;
    logic next_ok;
    cnt_t phase_len_q;
    cnt_t phase_len_d;

    // a channel counts as up only when it is not disabled as well
    function automatic logic ch_ok(
        input logic [`LED_NUM_CH-1:0] up,
        input logic [`LED_NUM_CH-1:0] off,
        input ch_idx_t idx
    );
        return up[idx] & ~off[idx];
    endfunction

    // mode decode; off wins over up so a disabled lane reads yellow
    assign all_up = &(CH_UP_I & ~CH_OFF_I);
    assign all_off = &CH_OFF_I;
    assign solid = all_up | all_off;
    assign last_ch = (ch_q == ch_idx_t'(`LED_NUM_CH - 1));

    // slot colour decode; a channel is read only on its slot's first edge,
    // so a status change later in the slot waits for the next pass
    assign next_ch = ch_q + ch_idx_t'(1);
    assign first_ok = ch_ok(CH_UP_I, CH_OFF_I, ch_idx_t'(0));
    assign next_ok = ch_ok(CH_UP_I, CH_OFF_I, next_ch);

    // sequencing: mode only re-decided at a sequence boundary
    always_comb begin
        state_d = state_q;
        ch_d = ch_q;
        led_d = led_q;
        t_load = 1'b0;
        t_len = SLOT_CYC;
        unique case (state_q)
            ST_SOLID: begin
                if (all_up) begin
                    led_d = '{green: 1'b1, yellow: 1'b0};
                end else if (all_off) begin
                    led_d = '{green: 1'b0, yellow: 1'b1};
                end else begin
                    state_d = ST_ON;
                    ch_d = '0;
                    t_load = 1'b1;
                    led_d.green = first_ok;
                    led_d.yellow = ~first_ok;
                end
            end
            ST_ON: begin
                if (t_done) begin
                    state_d = ST_GAP;
                    t_load = 1'b1;
                    led_d = '0;
                end
            end
            ST_GAP: begin
                if (t_done && last_ch) begin
                    state_d = ST_PAUSE;
                    t_load = 1'b1;
                    t_len = PAUSE_CYC;
                end else if (t_done) begin
                    state_d = ST_ON;
                    ch_d = next_ch;
                    t_load = 1'b1;
                    led_d.green = next_ok;
                    led_d.yellow = ~next_ok;
                end
            end
            ST_PAUSE: begin
                // boundary: hand back to solid decode, which restarts
                if (t_done) begin
                    state_d = ST_SOLID;
                end
            end
        endcase
    end

    led_timer u_timer (
        .clk_i(REF_CLK_I),
        .rst_i(SYS_RST_I),
        .load_i(t_load),
        .len_i(t_len),
        .done_o(t_done)
    );

    // state registers
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            state_q <= ST_SOLID;
            ch_q <= '0;
            led_q <= '0;
        end else begin
            state_q <= state_d;
            ch_q <= ch_d;
            led_q <= led_d;
        end
    end

    // independent element drives straight from flops
    assign LED_GREEN_O = led_q.green;
    assign LED_YELLOW_O = led_q.yellow;

    // cycles spent in the current phase; only the length checks read it,
    // it wraps harmlessly while the lamp sits in a solid colour
    assign phase_len_d = (state_d != state_q) ? cnt_t'(0)
                                              : phase_len_q + cnt_t'(1);

    // phase length counter, cleared on every state change
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            phase_len_q <= '0;
        end else begin
            phase_len_q <= phase_len_d;
        end
    end

    // checks
    chk_never_both: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I) !(LED_GREEN_O && LED_YELLOW_O))
        else $error("both leds lit");
    chk_solid_green: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I) (state_q == ST_SOLID && all_up)
        |=> LED_GREEN_O && !LED_YELLOW_O)
        else $error("solid green missing");
    chk_solid_yellow: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        (state_q == ST_SOLID && all_off && !all_up)
        |=> LED_YELLOW_O && !LED_GREEN_O)
        else $error("solid yellow missing");
    chk_slot_lit: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I) state_q == ST_ON
        |-> LED_GREEN_O != LED_YELLOW_O)
        else $error("slot not lit");
    chk_fault_yellow: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        (state_q != ST_ON && state_d == ST_ON
            && !(CH_UP_I[ch_d] && !CH_OFF_I[ch_d]))
        |=> LED_YELLOW_O && !LED_GREEN_O)
        else $error("fault not yellow");
    chk_gap_dark: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I) state_q == ST_GAP
        |-> !LED_GREEN_O && !LED_YELLOW_O)
        else $error("gap not dark");
    chk_ch_step: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        (state_q == ST_GAP && state_d == ST_ON)
        |=> ch_q == $past(ch_q) + ch_idx_t'(1))
        else $error("channel order wrong");
    chk_pause_last: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I) $rose(state_q == ST_PAUSE)
        |-> last_ch && !LED_GREEN_O && !LED_YELLOW_O)
        else $error("pause out of place");
    chk_mode_hold: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I) (state_q == ST_ON && solid)
        |=> state_q != ST_SOLID)
        else $error("mode changed mid sequence");
    chk_ok_green: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        (state_q != ST_ON && state_d == ST_ON
            && CH_UP_I[ch_d] && !CH_OFF_I[ch_d])
        |=> LED_GREEN_O && !LED_YELLOW_O)
        else $error("up channel not green");
    chk_slot_steady: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        (state_q == ST_ON && $past(state_q) == ST_ON)
        |-> $stable(LED_GREEN_O) && $stable(LED_YELLOW_O))
        else $error("slot colour changed mid slot");
    // the first edge out of reset is skipped, as state was forced there
    chk_solid_entry: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I)
        (!$past(SYS_RST_I) && state_q == ST_SOLID
            && $past(state_q) != ST_SOLID)
        |-> $past(state_q) == ST_PAUSE)
        else $error("mode left mid sequence");

    // phase ends, each closing one timed step of the blink pattern;
    // the counts are parameters, so a counter measures them instead
    sequence seq_lit_end;
        state_q == ST_ON && t_done;
    endsequence
    sequence seq_gap_end;
        state_q == ST_GAP && t_done;
    endsequence
    sequence seq_pause_end;
        state_q == ST_PAUSE && t_done;
    endsequence

    // phase lengths, seen on the last cycle of each phase
    chk_lit_len: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I) seq_lit_end
        |-> phase_len_q == SLOT_CYC - cnt_t'(1))
        else $error("lit slot length wrong");
    chk_gap_len: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I) seq_gap_end
        |-> phase_len_q == SLOT_CYC - cnt_t'(1))
        else $error("gap length wrong");
    chk_pause_len: assert property (@(posedge REF_CLK_I)
        disable iff (SYS_RST_I) seq_pause_end
        |-> phase_len_q == PAUSE_CYC - cnt_t'(1))
        else $error("pause length wrong");
endmodule // led_seq

// file: led_seq_cfg.svh
`ifndef LED_SEQ_CFG_SVH
`define LED_SEQ_CFG_SVH
// clock rate in kHz and phase times in ms
`define LED_CLK_KHZ 250000
`define LED_SLOT_MS 220
`define LED_PAUSE_MS 1760
// cycles per phase; both exceed 4096 so the top module takes them as params
`define LED_SLOT_CYC (`LED_SLOT_MS * `LED_CLK_KHZ)
`define LED_PAUSE_CYC (`LED_PAUSE_MS * `LED_CLK_KHZ)
// channel count of the module
`define LED_NUM_CH 8
`define LED_CH_W 3
`define LED_CNT_W 32
`endif

// file: led_seq_pkg.sv
`include "led_seq_cfg.svh"
package led_seq_pkg;
    typedef logic [`LED_CH_W-1:0] ch_idx_t;
    typedef logic [`LED_CNT_W-1:0] cnt_t;
    typedef struct packed {
        logic green;
        logic yellow;
    } led_drive_s;
    typedef enum logic [1:0] {
        ST_ON = 2'b00,
        ST_GAP = 2'b01,
        ST_PAUSE = 2'b11,
        ST_SOLID = 2'b10
    } seq_state_e;
endpackage

// file: led_timer.sv
`include "led_seq_cfg.svh"
module led_timer
    import led_seq_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // load a fresh duration
    input wire logic load_i,
    input wire cnt_t len_i,
    // terminal count, held high while the counter sits at zero
    output logic done_o
);
    cnt_t cnt_q;
    logic zero;

    // done is combinational from the counter so phases chain without gaps;
    // it must not look at load_i, which the sequencer derives from done_o
    assign zero = (cnt_q == '0);
    assign done_o = zero;

    // count down to zero and hold there until the next load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= len_i - cnt_t'(1);
        end else if (!zero) begin
            cnt_q <= cnt_q - cnt_t'(1);
        end
    end
endmodule // led_timer

// file: testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import led_seq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] up = 8'h00;
    logic [7:0] off = 8'h00;
    wire g;
    wire y;
    wire [1:0] col;
    int n_mismatch = 0;
    int samples_checked = 0;
    // short slot and pause keep the run small
    led_seq #(.SLOT_CYC(cnt_t'(4)), .PAUSE_CYC(cnt_t'(32))) led_seq_inst (
        .REF_CLK_I(clk), .SYS_RST_I(rst), .CH_UP_I(up), .CH_OFF_I(off),
        .LED_GREEN_O(g), .LED_YELLOW_O(y));
    led_model led_model_inst (.green_i(g), .yellow_i(y), .color_o(col));
    // 4 ns clock
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic cmp(string what, logic [1:0] exp);
        samples_checked++;
        if (col !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0d seen %0d", what, exp, col);
        end
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // status is set while reset is held, so the first decode sees it
    task automatic restart(logic [7:0] u, logic [7:0] o);
        rst = 1'b1;
        up = u;
        off = o;
        repeat (2) step();
        rst = 1'b0;
    endtask
    task automatic solid_modes();
        restart(8'hff, 8'h00);
        repeat (3) step();
        repeat (16) begin
            step();
            cmp("all up", 2'h1);
        end
        off = 8'hff; // disabled wins over up
        repeat (2) step();
        repeat (16) begin
            step();
            cmp("all off", 2'h2);
        end
    endtask
    // two passes; in the second, status flips to all up inside slot 0
    task automatic blink_walk();
        int k;
        logic [1:0] e;
        restart(8'h97, 8'h34);
        for (k = 0; k < 10 && col === 2'h0; k++) step();
        if (k == 10) begin
            n_mismatch++;
            $display("mismatch first slot expected lit seen dark");
            conclude();
        end
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 8; c++) begin
                e = (up[c] && !off[c]) ? 2'h1 : 2'h2;
                if (p == 1 && c == 0) begin
                    up = 8'hff;
                    off = 8'h00;
                end
                repeat (4) begin
                    cmp($sformatf("slot %0d", c), e);
                    step();
                end
                repeat (c == 7 ? 37 : 4) begin
                    cmp($sformatf("gap %0d", c), 2'h0);
                    step();
                end
            end
        end
        // mode change held back to the sequence boundary
        repeat (2) step();
        repeat (8) begin
            cmp("solid after", 2'h1);
            step();
        end
    endtask
    initial begin
        solid_modes();
        blink_walk();
        conclude();
    end
endmodule // testbench
